/* dacr_ctrl_regs.sv */
// DSP array control register bank with host access and DSP-facing outputs
// How it works
// - Enable register at 0x1006, bit per DSP
// - Enables clear at power-up, upper bits stored
// - PLL select in 0x1200 bits 9..8, only 00; the logic drives out whatever value is written
// - 0x1200 bits 7..0 hold DSP resets
// - 0x1202 holds boot mode and flag straps
// - Boot straps reach a DSP only in reset
// - Boot register powers up as 0x0DAC
// - 0x1204 bits drive DSP flag interrupts
// - 0x1206 bits 11..0 light twelve lamps
// - Ten interrupt sources OR onto INTA#
// - Offsets decoded from base, 16-bit registers
// - Status at 0x1004 shows pending DSP lines
`timescale 1ns/1ns
module dacr_ctrl_regs (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Host register access
    input wire logic [dacr_pkg::DACR_AW-1:0] bar_base,
    input wire logic [dacr_pkg::DACR_AW-1:0] acc_addr,
    input wire logic acc_wr,
    input wire logic acc_rd,
    input wire logic [dacr_pkg::DACR_DW-1:0] acc_wdata,
    output logic [dacr_pkg::DACR_DW-1:0] acc_rdata,
    output logic acc_rd_ack,
    // Interrupt sources and host interrupt
    input wire logic [1:0] tsi_irq_req,
    input wire logic [dacr_pkg::DACR_NDSP-1:0] dsp_irq_n_pin,
    output logic host_inta_n,
    // DSP control
    output logic [1:0] pll_cfg_sel,
    output logic [dacr_pkg::DACR_NDSP-1:0] proc_reset_bit,
    output logic [dacr_pkg::DACR_NDSP*dacr_pkg::DACR_BOOT_W-1:0] boot_sel,
    output logic [dacr_pkg::DACR_NDSP*dacr_pkg::DACR_STRAP_W-1:0] strap_flag_out,
    output logic [dacr_pkg::DACR_NDSP-1:0] strap_flag_oe,
    output logic [dacr_pkg::DACR_NDSP-1:0] proc_irq_input_pin,
    // Front panel
    output logic [dacr_pkg::DACR_NLAMP-1:0] lamp_on
);
    import dacr_pkg::*;

    dacr_dsp_if dsp_ifc ();

    logic [DACR_AW-1:0] offset;
    dacr_sel_t sel;
    logic [DACR_DW-1:0] en_q, en_d;
    logic [DACR_DW-1:0] pllrst_q, pllrst_d;
    logic [DACR_DW-1:0] boot_q, boot_d;
    logic [DACR_DW-1:0] trig_q, trig_d;
    logic [DACR_DW-1:0] lamp_q, lamp_d;
    logic [DACR_DW-1:0] rdata_q, rdata_d;
    logic rd_ack_q, rd_ack_d;
    logic inta_n_q, inta_n_d;
    logic [DACR_DW-1:0] stat_word;

    // Offset decode from base
    // Anything outside the six offsets selects nothing and reads as zero
    always_comb begin
        offset = acc_addr - bar_base;
        case (offset)
            DACR_OFS_STAT: sel = DACR_SEL_STAT;
            DACR_OFS_EN: sel = DACR_SEL_EN;
            DACR_OFS_PLLRST: sel = DACR_SEL_PLLRST;
            DACR_OFS_BOOT: sel = DACR_SEL_BOOT;
            DACR_OFS_TRIG: sel = DACR_SEL_TRIG;
            DACR_OFS_LAMP: sel = DACR_SEL_LAMP;
            default: sel = DACR_SEL_NONE;
        endcase
    end

    assign stat_word = {{(DACR_DW-DACR_NDSP){1'b0}}, dsp_ifc.pend};

    // Register write next values; full words stored, status is read-only
    always_comb begin
        en_d = en_q;
        pllrst_d = pllrst_q;
        boot_d = boot_q;
        trig_d = trig_q;
        lamp_d = lamp_q;
        if (acc_wr) begin
            case (sel)
                DACR_SEL_EN: en_d = acc_wdata;
                DACR_SEL_PLLRST: pllrst_d = acc_wdata;
                DACR_SEL_BOOT: boot_d = acc_wdata;
                DACR_SEL_TRIG: trig_d = acc_wdata;
                DACR_SEL_LAMP: lamp_d = acc_wdata;
                default: en_d = en_q;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            en_q <= DACR_EN_RST;
            pllrst_q <= DACR_PLLRST_RST;
            boot_q <= DACR_BOOT_RST;
            trig_q <= DACR_TRIG_RST;
            lamp_q <= DACR_LAMP_RST;
        end else begin
            en_q <= en_d;
            pllrst_q <= pllrst_d;
            boot_q <= boot_d;
            trig_q <= trig_d;
            lamp_q <= lamp_d;
        end
    end

    // Read-back of whole words
    // Read data is registered, so the answer comes one cycle after the request
    always_comb begin
        rd_ack_d = acc_rd;
        rdata_d = DACR_RD_NONE;
        if (acc_rd) begin
            case (sel)
                DACR_SEL_STAT: rdata_d = stat_word;
                DACR_SEL_EN: rdata_d = en_q;
                DACR_SEL_PLLRST: rdata_d = pllrst_q;
                DACR_SEL_BOOT: rdata_d = boot_q;
                DACR_SEL_TRIG: rdata_d = trig_q;
                DACR_SEL_LAMP: rdata_d = lamp_q;
                default: rdata_d = DACR_RD_NONE;
            endcase
        end
    end

    always_comb begin
        inta_n_d = ~((|(dsp_ifc.pend & en_q[DACR_NDSP-1:0])) | (|tsi_irq_req));
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= DACR_RD_NONE;
            rd_ack_q <= 1'b0;
            inta_n_q <= 1'b1;
        end else begin
            rdata_q <= rdata_d;
            rd_ack_q <= rd_ack_d;
            inta_n_q <= inta_n_d;
        end
    end

    // Reset bits and straps to side logic
    assign dsp_ifc.rst = pllrst_q[DACR_NDSP-1:DACR_RST_LSB];
    assign dsp_ifc.boot_cfg = boot_q[DACR_CFG_MSB:0];

    dacr_dsp_side dacr_dsp_side_inst (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .dsp_irq_n_pin(dsp_irq_n_pin),
        .ifc(dsp_ifc.side)
    );

    // Outputs straight from flip-flops
    assign acc_rdata = rdata_q;
    assign acc_rd_ack = rd_ack_q;
    assign host_inta_n = inta_n_q;
    // PLL select drives out as stored
    assign pll_cfg_sel = pllrst_q[DACR_PLL_MSB:DACR_PLL_LSB];
    assign proc_reset_bit = pllrst_q[DACR_NDSP-1:DACR_RST_LSB];
    assign boot_sel = dsp_ifc.boot_o;
    assign strap_flag_out = dsp_ifc.strap_o;
    assign strap_flag_oe = dsp_ifc.oe_o;
    assign proc_irq_input_pin = trig_q[DACR_NDSP-1:0];
    assign lamp_on = lamp_q[DACR_LAMP_MSB:0];

    // Register writes land one cycle on, and nothing else moves a register
    // Enable write lands
    AST_EN_WRITE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (acc_wr && sel == DACR_SEL_EN) |=> (en_q == $past(acc_wdata)))
        else $error("enable register did not take the write");

    AST_EN_KEEP: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !(acc_wr && sel == DACR_SEL_EN) |=> $stable(en_q))
        else $error("enable register changed without a write");

    AST_RESET_OUT: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (acc_wr && sel == DACR_SEL_PLLRST) |=>
        (proc_reset_bit == $past(acc_wdata[7:0])) && (pll_cfg_sel == $past(acc_wdata[9:8])))
        else $error("reset or pll select output wrong after write");

    AST_PLL_KEEP: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !(acc_wr && sel == DACR_SEL_PLLRST) |=> $stable(pll_cfg_sel) && $stable(proc_reset_bit))
        else $error("pll select or reset bits changed without a write");

    AST_BOOT_WRITE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (acc_wr && sel == DACR_SEL_BOOT) |=> (boot_q == $past(acc_wdata)))
        else $error("boot register did not take the write");

    AST_BOOT_KEEP: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !(acc_wr && sel == DACR_SEL_BOOT) |=> $stable(boot_q))
        else $error("boot register changed without a write");

    AST_TRIG_OUT: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (acc_wr && sel == DACR_SEL_TRIG) |=> (proc_irq_input_pin == $past(acc_wdata[7:0])))
        else $error("flag interrupt output wrong after write");

    AST_TRIG_KEEP: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !(acc_wr && sel == DACR_SEL_TRIG) |=> $stable(proc_irq_input_pin))
        else $error("flag interrupt output changed without a write");

    AST_LAMP_OUT: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (acc_wr && sel == DACR_SEL_LAMP) |=> (lamp_on == $past(acc_wdata[11:0])))
        else $error("lamp output wrong after write");

    AST_LAMP_KEEP: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !(acc_wr && sel == DACR_SEL_LAMP) |=> $stable(lamp_on))
        else $error("lamp output changed without a write");

    AST_WR_IGNORED: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (acc_wr && (sel == DACR_SEL_NONE || sel == DACR_SEL_STAT)) |=>
        $stable(en_q) && $stable(pllrst_q) && $stable(boot_q)
        && $stable(trig_q) && $stable(lamp_q))
        else $error("ignored write changed a register");

    // Reads answer exactly one cycle later and stand for that cycle only
    // Ack follows read
    AST_RD_ACK: assert property (@(posedge sys_clk) disable iff (!rst_n)
        acc_rd |=> acc_rd_ack)
        else $error("read not acknowledged one cycle later");

    AST_RD_IDLE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !acc_rd |=> !acc_rd_ack && (acc_rdata == 16'h0000))
        else $error("ack or data seen without a read");

    AST_STAT_READ: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (acc_rd && sel == DACR_SEL_STAT) |=>
        acc_rd_ack && (acc_rdata == {8'h00, $past(dsp_ifc.pend)}))
        else $error("status read does not show pending lines");

    AST_EN_READ: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (acc_rd && sel == DACR_SEL_EN) |=> (acc_rdata == $past(en_q)))
        else $error("enable register read-back mismatch");

    AST_PLLRST_READ: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (acc_rd && sel == DACR_SEL_PLLRST) |=> (acc_rdata == $past(pllrst_q)))
        else $error("reset register read-back mismatch");

    AST_BOOT_READ: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (acc_wr && sel == DACR_SEL_BOOT) ##1 (acc_rd && sel == DACR_SEL_BOOT && !acc_wr)
        |=> (acc_rdata == $past(acc_wdata, 2)))
        else $error("boot register read-back mismatch");

    AST_TRIG_READ: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (acc_rd && sel == DACR_SEL_TRIG) |=> (acc_rdata == $past(trig_q)))
        else $error("trigger register read-back mismatch");

    AST_LAMP_READ: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (acc_rd && sel == DACR_SEL_LAMP) |=> (acc_rdata == $past(lamp_q)))
        else $error("lamp register read-back mismatch");

    AST_UNMAPPED: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (acc_rd && sel == DACR_SEL_NONE) |=> acc_rd_ack && (acc_rdata == 16'h0000))
        else $error("unmapped read not zero");

    AST_INTA_OR: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (|tsi_irq_req) |=> !host_inta_n)
        else $error("internal request did not assert host interrupt");

    AST_INTA_DSP: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (|(dsp_ifc.pend & en_q[DACR_NDSP-1:0])) |=> !host_inta_n)
        else $error("enabled pending line did not assert host interrupt");

    AST_INTA_GATE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ((tsi_irq_req == 2'h0) && ((dsp_ifc.pend & en_q[7:0]) == 8'h00)) |=> host_inta_n)
        else $error("host interrupt asserted with nothing enabled and pending");
endmodule : dacr_ctrl_regs

/* dacr_pkg.sv */
// Constants shared by the DSP array control register block
package dacr_pkg;
    // Register word and address widths
    localparam int DACR_DW = 16;
    localparam int DACR_AW = 32;
    localparam int DACR_NDSP = 8;
    localparam int DACR_NLAMP = 12;
    localparam int DACR_BOOT_W = 3;
    localparam int DACR_STRAP_W = 10;
    localparam int DACR_CFG_W = 13;
    // Register offsets from the configured base address
    localparam logic [31:0] DACR_OFS_STAT = 32'h0000_1004;
    localparam logic [31:0] DACR_OFS_EN = 32'h0000_1006;
    localparam logic [31:0] DACR_OFS_PLLRST = 32'h0000_1200;
    localparam logic [31:0] DACR_OFS_BOOT = 32'h0000_1202;
    localparam logic [31:0] DACR_OFS_TRIG = 32'h0000_1204;
    localparam logic [31:0] DACR_OFS_LAMP = 32'h0000_1206;
    // Power-up values
    localparam logic [15:0] DACR_EN_RST = 16'h0000;
    localparam logic [15:0] DACR_PLLRST_RST = 16'h0000;
    localparam logic [15:0] DACR_BOOT_RST = 16'h0DAC;
    localparam logic [15:0] DACR_TRIG_RST = 16'h0000;
    localparam logic [15:0] DACR_LAMP_RST = 16'h0000;
    localparam logic [15:0] DACR_RD_NONE = 16'h0000;
    // Field positions
    localparam int DACR_RST_LSB = 0;
    localparam int DACR_PLL_LSB = 8;
    localparam int DACR_PLL_MSB = 9;
    localparam int DACR_STRAP_LSB = 0;
    localparam int DACR_BOOT_LSB = 10;
    localparam int DACR_BOOT_MSB = 12;
    localparam int DACR_CFG_MSB = 12;
    localparam int DACR_LAMP_MSB = 11;
    // Latched per-DSP strap power-up values
    localparam logic [2:0] DACR_BOOT_SEL_RST = 3'h3;
    localparam logic [9:0] DACR_STRAP_RST = 10'h1AC;
    // Register select codes
    typedef enum logic [2:0] {
        DACR_SEL_NONE = 3'b000,
        DACR_SEL_STAT = 3'b001,
        DACR_SEL_EN = 3'b010,
        DACR_SEL_PLLRST = 3'b011,
        DACR_SEL_BOOT = 3'b100,
        DACR_SEL_TRIG = 3'b101,
        DACR_SEL_LAMP = 3'b110
    } dacr_sel_t;
endpackage : dacr_pkg

/* dacr_dsp_if.sv */
// Carrier between the register file and the per-DSP side logic
`timescale 1ns/1ns
interface dacr_dsp_if;
    import dacr_pkg::*;
    logic [DACR_NDSP-1:0] rst;
    logic [DACR_CFG_W-1:0] boot_cfg;
    logic [DACR_NDSP-1:0] pend;
    logic [DACR_NDSP*DACR_BOOT_W-1:0] boot_o;
    logic [DACR_NDSP*DACR_STRAP_W-1:0] strap_o;
    logic [DACR_NDSP-1:0] oe_o;
    modport regs (output rst, output boot_cfg, input pend, input boot_o, input strap_o,
        input oe_o);
    modport side (input rst, input boot_cfg, output pend, output boot_o, output strap_o,
        output oe_o);
endinterface : dacr_dsp_if

/* dacr_dsp_side.sv */
// Per-DSP interrupt synchronisers and strap latches
`timescale 1ns/1ns
module dacr_dsp_side (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Interrupt pins from the DSPs, active low
    input wire logic [dacr_pkg::DACR_NDSP-1:0] dsp_irq_n_pin,
    // Register side
    dacr_dsp_if.side ifc
);
    import dacr_pkg::*;

    logic [DACR_NDSP-1:0] sync1_q, sync1_d, sync2_q, sync2_d;
    logic [DACR_NDSP*DACR_BOOT_W-1:0] boot_q, boot_d;
    logic [DACR_NDSP*DACR_STRAP_W-1:0] strap_q, strap_d;
    logic [DACR_NDSP-1:0] oe_q, oe_d;

    // Two-stage synchroniser; only the second stage is looked at
    always_comb begin
        sync1_d = dsp_irq_n_pin;
        sync2_d = sync1_q;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= {DACR_NDSP{1'b1}};
            sync2_q <= {DACR_NDSP{1'b1}};
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
        end
    end

    assign ifc.pend = ~sync2_q;

    // Straps follow register only in reset
    // The latch keeps the value a DSP booted with, so later writes stay harmless
    genvar gi;
    generate
        for (gi = 0; gi < DACR_NDSP; gi++) begin : g_dsp
            always_comb begin
                boot_d[gi*DACR_BOOT_W +: DACR_BOOT_W] = boot_q[gi*DACR_BOOT_W +: DACR_BOOT_W];
                strap_d[gi*DACR_STRAP_W +: DACR_STRAP_W] =
                    strap_q[gi*DACR_STRAP_W +: DACR_STRAP_W];
                oe_d[gi] = ifc.rst[gi];
                if (ifc.rst[gi]) begin
                    boot_d[gi*DACR_BOOT_W +: DACR_BOOT_W] =
                        ifc.boot_cfg[DACR_BOOT_MSB:DACR_BOOT_LSB];
                    strap_d[gi*DACR_STRAP_W +: DACR_STRAP_W] =
                        ifc.boot_cfg[DACR_BOOT_LSB-1:DACR_STRAP_LSB];
                end
            end
        end
    endgenerate

    // Latches start at the power-up straps
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            boot_q <= {DACR_NDSP{DACR_BOOT_SEL_RST}};
            strap_q <= {DACR_NDSP{DACR_STRAP_RST}};
            oe_q <= '0;
        end else begin
            boot_q <= boot_d;
            strap_q <= strap_d;
            oe_q <= oe_d;
        end
    end

    assign ifc.boot_o = boot_q;
    assign ifc.strap_o = strap_q;
    assign ifc.oe_o = oe_q;

    AST_STRAP_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ifc.rst == '0) |=> $stable(strap_q) && $stable(boot_q))
        else $error("strap latch changed outside reset");

    AST_STRAP_TRACK: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ifc.rst[0] |=> (strap_q[DACR_STRAP_W-1:0] == $past(ifc.boot_cfg[DACR_STRAP_W-1:0]))
        && oe_q[0])
        else $error("strap not presented during reset");
endmodule : dacr_dsp_side

/* dacr_dsp_model.sv */
// Behavioural model of the eight DSPs facing the control register block
`timescale 1ns/1ns
module dacr_dsp_model (
    // Clock
    input wire logic sys_clk,
    // Stimulus from the bench
    input wire logic [7:0] irq_req,
    // Reset and strap lines from the block
    input wire logic [7:0] proc_reset_bit,
    input wire logic [7:0] strap_flag_oe,
    input wire logic [79:0] strap_flag_out,
    // Interrupt pins and captured straps
    output logic [7:0] dsp_irq_n_pin,
    output logic [79:0] cap_strap
);
    assign dsp_irq_n_pin = ~irq_req;
    // Straps seen only while the core is held in reset, like a real boot sampler
    initial cap_strap = '0;
    always @(posedge sys_clk) begin
        for (int i = 0; i < 8; i++) begin
            if (proc_reset_bit[i] && strap_flag_oe[i]) begin
                cap_strap[10*i+:10] <= strap_flag_out[10*i+:10];
            end
        end
    end
endmodule : dacr_dsp_model

/* dacr_ctrl_regs_tb.sv */
// Self-checking bench for the DSP array control register block
`timescale 1ns/1ns
module dacr_ctrl_regs_tb;
    import dacr_pkg::*;
    localparam logic [31:0] BASE = 32'h8000_0000;
    logic sys_clk, rst_n, acc_wr, acc_rd, acc_rd_ack, host_inta_n;
    logic [31:0] acc_addr;
    logic [15:0] acc_wdata, acc_rdata;
    logic [1:0] tsi_irq_req, pll_cfg_sel;
    logic [7:0] dsp_irq_n_pin, proc_reset_bit, strap_flag_oe, proc_irq_input_pin, irq_req;
    logic [23:0] boot_sel;
    logic [79:0] strap_flag_out, cap_strap;
    logic [11:0] lamp_on;
    int err_total, n_checks;

    dacr_ctrl_regs dacr_ctrl_regs_inst (.sys_clk(sys_clk), .rst_n(rst_n), .bar_base(BASE),
        .acc_addr(acc_addr), .acc_wr(acc_wr), .acc_rd(acc_rd), .acc_wdata(acc_wdata),
        .acc_rdata(acc_rdata), .acc_rd_ack(acc_rd_ack), .tsi_irq_req(tsi_irq_req),
        .dsp_irq_n_pin(dsp_irq_n_pin), .host_inta_n(host_inta_n), .pll_cfg_sel(pll_cfg_sel),
        .proc_reset_bit(proc_reset_bit), .boot_sel(boot_sel), .strap_flag_out(strap_flag_out),
        .strap_flag_oe(strap_flag_oe), .proc_irq_input_pin(proc_irq_input_pin),
        .lamp_on(lamp_on));
    dacr_dsp_model dacr_dsp_model_inst (.sys_clk(sys_clk), .irq_req(irq_req),
        .proc_reset_bit(proc_reset_bit), .strap_flag_oe(strap_flag_oe),
        .strap_flag_out(strap_flag_out), .dsp_irq_n_pin(dsp_irq_n_pin), .cap_strap(cap_strap));

    // Clock generator
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // Compare and count
    task chk(input string nm, input logic [79:0] seen, input logic [79:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // One-cycle write strobe, launched off the falling edge
    task wr(input logic [31:0] ofs, input logic [15:0] d);
        @(negedge sys_clk);
        acc_wr = 1'b1;
        acc_addr = BASE + ofs;
        acc_wdata = d;
        @(negedge sys_clk);
        acc_wr = 1'b0;
    endtask : wr

    // Read: ack and data stand one cycle, so look at them in that cycle
    task rd(input logic [31:0] ofs, input logic [15:0] exp);
        @(negedge sys_clk);
        acc_rd = 1'b1;
        acc_addr = BASE + ofs;
        @(negedge sys_clk);
        acc_rd = 1'b0;
        chk("read ack", acc_rd_ack, 1'b1);
        chk("read data", acc_rdata, exp);
    endtask : rd

    // Write, then read the same word on the very next cycle
    task wr_rd(input logic [31:0] ofs, input logic [15:0] d);
        @(negedge sys_clk);
        acc_wr = 1'b1;
        acc_addr = BASE + ofs;
        acc_wdata = d;
        @(negedge sys_clk);
        acc_wr = 1'b0;
        acc_rd = 1'b1;
        @(negedge sys_clk);
        acc_rd = 1'b0;
        chk("back to back ack", acc_rd_ack, 1'b1);
        chk("back to back data", acc_rdata, d);
    endtask : wr_rd

    task stop_test;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test

    // Watchdog, far beyond the roughly 145 cycles the tests need
    initial begin
        #(50 * 4000);
        err_total++;
        stop_test();
    end

    // Main sequence
    initial begin
        rst_n = 1'b0;
        acc_wr = 1'b0;
        acc_rd = 1'b0;
        acc_addr = '0;
        acc_wdata = '0;
        tsi_irq_req = 2'b00;
        irq_req = 8'h00;
        err_total = 0;
        n_checks = 0;
        repeat (8) @(negedge sys_clk);
        rst_n = 1'b1;
        // Power-up state of outputs and registers
        chk("boot_sel", boot_sel, {8{3'h3}});
        chk("straps", strap_flag_out, {8{10'h1AC}});
        chk("oe", strap_flag_oe, 8'h00);
        chk("resets", proc_reset_bit, 8'h00);
        chk("pll", pll_cfg_sel, 2'b00);
        chk("trig", proc_irq_input_pin, 8'h00);
        chk("lamps", lamp_on, 12'h000);
        chk("inta", host_inta_n, 1'b1);
        rd(DACR_OFS_EN, 16'h0000);
        rd(DACR_OFS_PLLRST, 16'h0000);
        rd(DACR_OFS_BOOT, 16'h0DAC);
        rd(DACR_OFS_TRIG, 16'h0000);
        rd(DACR_OFS_LAMP, 16'h0000);
        rd(DACR_OFS_STAT, 16'h0000);
        $display("test reset done");
        // Full-word write and read back, unused bits included
        wr(DACR_OFS_EN, 16'hFF00);
        rd(DACR_OFS_EN, 16'hFF00);
        // software keeps the PLL select at 00
        wr(DACR_OFS_PLLRST, 16'hFC5B);
        chk("resets", proc_reset_bit, 8'h5B);
        chk("pll", pll_cfg_sel, 2'b00);
        rd(DACR_OFS_PLLRST, 16'hFC5B);
        wr(DACR_OFS_TRIG, 16'hFFA5);
        chk("trig", proc_irq_input_pin, 8'hA5);
        rd(DACR_OFS_TRIG, 16'hFFA5);
        wr(DACR_OFS_LAMP, 16'hF123);
        chk("lamps", lamp_on, 12'h123);
        rd(DACR_OFS_LAMP, 16'hF123);
        wr(DACR_OFS_STAT, 16'h00FF);
        rd(DACR_OFS_STAT, 16'h0000);
        wr(32'h0000_1208, 16'hFFFF);
        rd(32'h0000_1208, 16'h0000);
        $display("test access done");
        wr(DACR_OFS_BOOT, 16'h1555);
        repeat (2) @(negedge sys_clk);
        for (int i = 0; i < 8; i++) begin
            chk("boot_sel", boot_sel[3*i+:3], (8'h5B >> i) & 1 ? 3'h5 : 3'h3);
            chk("straps", strap_flag_out[10*i+:10], (8'h5B >> i) & 1 ? 10'h155 : 10'h1AC);
        end
        chk("oe", strap_flag_oe, 8'h5B);
        wr(DACR_OFS_PLLRST, 16'h0000);
        repeat (2) @(negedge sys_clk);
        chk("oe", strap_flag_oe, 8'h00);
        wr_rd(DACR_OFS_BOOT, 16'h0DAC);
        repeat (2) @(negedge sys_clk);
        chk("held straps", strap_flag_out[19:10], 10'h155);
        chk("held boot", boot_sel[5:3], 3'h5);
        chk("dsp seen", cap_strap[19:0], {10'h155, 10'h155});
        $display("test straps done");
        // Masked, then enabled DSP interrupt; internal sources
        irq_req = 8'h01;
        repeat (4) @(negedge sys_clk);
        chk("inta", host_inta_n, 1'b1);
        rd(DACR_OFS_STAT, 16'h0001);
        for (int i = 0; i < 8; i++) begin
            irq_req = 8'h01 << i;
            wr(DACR_OFS_EN, 16'h0001 << i);
            repeat (3) @(negedge sys_clk);
            chk("inta", host_inta_n, 1'b0);
            wr(DACR_OFS_EN, 16'h00FF ^ (16'h0001 << i));
            repeat (2) @(negedge sys_clk);
            chk("inta", host_inta_n, 1'b1);
        end
        irq_req = 8'h00;
        tsi_irq_req = 2'b10;
        repeat (2) @(negedge sys_clk);
        chk("inta", host_inta_n, 1'b0);
        tsi_irq_req = 2'b00;
        repeat (2) @(negedge sys_clk);
        chk("inta", host_inta_n, 1'b1);
        tsi_irq_req = 2'b01;
        repeat (2) @(negedge sys_clk);
        chk("inta", host_inta_n, 1'b0);
        tsi_irq_req = 2'b00;
        repeat (2) @(negedge sys_clk);
        chk("inta", host_inta_n, 1'b1);
        $display("test interrupts done");
        stop_test();
    end
endmodule : dacr_ctrl_regs_tb
